//--- rtl/asm_aux_master.sv
// auxiliary sensor master: registers, polling, frame building
// Behaviour
// - acc enable stores three axes
// - aux enable stores three aux axes
// - header enable prefixes each frame
// - line one tag when enabled
// - line two tag when enabled
// - target address from bits seven..one
// - burst field selects 1,2,6,8 bytes
// - manual bit selects setup mode
// - read transfers use fetch pointer
// - write transfers use store pointer
// - write payload from store value
// - data mode polls at coded rate
// - trigger offset in 2.5 ms units
`include "asm_params.svh"
module asm_aux_master #(
  parameter int unsigned UNIT_CYC = `ASM_CLK_HZ / 1000000 * `ASM_UNIT_US
) (
  input  wire logic                clk,        // 40 MHz clock
  input  wire logic                rst_n,      // async reset, active low
  input  wire logic                wb_cyc_i,   // wishbone cycle
  input  wire logic                wb_stb_i,   // wishbone strobe
  input  wire logic                wb_we_i,    // wishbone write
  input  wire logic [8:0]          wb_adr_i,   // byte address
  input  wire logic [3:0]          wb_sel_i,   // byte lanes
  input  wire logic [31:0]         wb_dat_i,   // write data
  output logic [31:0]              wb_dat_o,   // read data
  output logic                     wb_ack_o,   // acknowledge
  input  wire logic [47:0]         accSample,  // x,y,z, low byte first
  input  wire logic                accStrobe,  // new acc sample
  input  wire logic                irqLineOne, // interrupt 1 level
  input  wire logic                irqLineTwo, // interrupt 2 level
  output asm_pkg::asm_fbyte_t      frameByte,  // frame stream byte
  output logic                     frameValid, // frameByte valid
  input  wire logic                frameReady, // consumer ready
  input  wire logic                sclIn,      // scl pin level
  output logic                     sclOut,     // scl drive value
  output logic                     sclOe,      // scl drive enable
  input  wire logic                sdaIn,      // sda pin level
  output logic                     sdaOut,     // sda drive value
  output logic                     sdaOe       // sda drive enable
);
  logic [7:0]  rate_r, frame_r, target_r, setup_r;
  logic [7:0]  fetch_r, storePtr_r, storeVal_r;
  logic        access, wrEn;
  logic [6:0]  idx;
  logic        pendWr_r, pendRd_r, pendPoll_r;
  logic        engStart_r;
  asm_pkg::asm_i2c_req_t engReq_r;
  logic        engBusy, engDone, engNack, rxValid;
  logic [7:0]  rxData;
  logic [2:0]  rxIdx;
  logic [3:0]  burstLen;
  logic        dataMode, rateOk;
  logic [16:0] uCnt_r;
  logic        unitTick;
  logic [10:0] perCnt_r, perLen;
  logic [4:0]  offCnt_r;
  logic        armed_r;
  logic        pollRead_r;
  logic [7:0]  auxBuf [0:7];
  logic [7:0]  frame [0:`ASM_FRAME_MAX-1];
  logic [3:0]  fLen_r, fIdx_r;
  logic        trigger;
  logic [3:0]  hLen, aLen;
  logic [1:0]  tags;
  logic        bufReady;
  asm_pkg::asm_fbyte_t bufIn;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrEn   = access && wb_we_i && wb_sel_i[0];
  assign idx    = wb_adr_i[8:2];

  assign dataMode = !setup_r[`ASM_BIT_MANUAL];
  assign rateOk = (rate_r[3:0] >= `ASM_RATE_MIN) &&
                  (rate_r[3:0] <= `ASM_RATE_MAX);
  assign perLen = `ASM_POLL_SLOW >> (rate_r[3:0] - `ASM_RATE_MIN);

  always_comb begin
    case (setup_r[1:0])
      2'h0: burstLen = `ASM_BL1;
      2'h1: burstLen = `ASM_BL2;
      2'h2: burstLen = `ASM_BL6;
      default: burstLen = `ASM_BL8;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_r     <= `ASM_RST_RATE;
      frame_r    <= `ASM_RST_FRAME;
      target_r   <= `ASM_RST_TARGET;
      setup_r    <= `ASM_RST_SETUP;
      fetch_r    <= `ASM_RST_FETCH;
      storePtr_r <= `ASM_RST_STORE_PTR;
      storeVal_r <= `ASM_RST_STORE_VAL;
    end else if (wrEn) begin
      case (idx)
        `ASM_IDX_RATE:      rate_r     <= wb_dat_i[7:0];
        `ASM_IDX_FRAME:     frame_r    <= wb_dat_i[7:0] & `ASM_MSK_FRAME;
        `ASM_IDX_TARGET:    target_r   <= wb_dat_i[7:0] & `ASM_MSK_TARGET;
        `ASM_IDX_SETUP:     setup_r    <= wb_dat_i[7:0] & `ASM_MSK_SETUP;
        `ASM_IDX_FETCH:     fetch_r    <= wb_dat_i[7:0];
        `ASM_IDX_STORE_PTR: storePtr_r <= wb_dat_i[7:0];
        `ASM_IDX_STORE_VAL: storeVal_r <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // single-cycle ack one edge after the strobe; unmapped reads give 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && !wb_we_i) begin
        case (idx)
          `ASM_IDX_RATE:      wb_dat_o[7:0] <= rate_r;
          `ASM_IDX_FRAME:     wb_dat_o[7:0] <= frame_r;
          `ASM_IDX_STATUS:
            wb_dat_o[7:0] <= {4'h0, (fIdx_r != fLen_r), pollRead_r,
                              engNack, engBusy};
          `ASM_IDX_TARGET:    wb_dat_o[7:0] <= target_r;
          `ASM_IDX_SETUP:     wb_dat_o[7:0] <= setup_r;
          `ASM_IDX_FETCH:     wb_dat_o[7:0] <= fetch_r;
          `ASM_IDX_STORE_PTR: wb_dat_o[7:0] <= storePtr_r;
          `ASM_IDX_STORE_VAL: wb_dat_o[7:0] <= storeVal_r;
          default: ;
        endcase
      end
    end
  end

  // unit tick of 1.25 ms, half the offset step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) uCnt_r <= '0;
    else if (unitTick) uCnt_r <= '0;
    else uCnt_r <= uCnt_r + 17'h1;
  end
  assign unitTick = (uCnt_r == 17'(UNIT_CYC - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      perCnt_r <= '0;
      offCnt_r <= '0;
      armed_r  <= 1'b0;
    end else if (!dataMode || !rateOk) begin
      perCnt_r <= '0;
      armed_r  <= 1'b0;
    end else if (unitTick) begin
      if (perCnt_r >= perLen - 11'h1) begin
        perCnt_r <= '0;
        offCnt_r <= 5'(rate_r[7:4] * `ASM_OFFSET_UNITS);
        armed_r  <= 1'b1;
      end else begin
        perCnt_r <= perCnt_r + 11'h1;
        if (offCnt_r != 5'h0) offCnt_r <= offCnt_r - 5'h1;
      end
    end else if (armed_r && offCnt_r == 5'h0) begin
      armed_r <= 1'b0;
    end
  end

  // pending requests; a new request in the accept cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendWr_r   <= 1'b0;
      pendRd_r   <= 1'b0;
      pendPoll_r <= 1'b0;
    end else begin
      if (wrEn && !dataMode && idx == `ASM_IDX_STORE_VAL) pendWr_r <= 1'b1;
      else if (engStart_r && engReq_r.op == asm_pkg::ASM_OP_WRITE)
        pendWr_r <= 1'b0;
      if (wrEn && !dataMode && idx == `ASM_IDX_FETCH) pendRd_r <= 1'b1;
      else if (engStart_r && !pendWr_r && !pollRead_r) pendRd_r <= 1'b0;
      if (armed_r && offCnt_r == 5'h0 && !unitTick) pendPoll_r <= 1'b1;
      else if (engStart_r && pollRead_r) pendPoll_r <= 1'b0;
      else if (!dataMode) pendPoll_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engStart_r <= 1'b0;
      engReq_r   <= '0;
      pollRead_r <= 1'b0;
    end else begin
      engStart_r <= 1'b0;
      if (!engBusy && !engStart_r && (pendWr_r || pendRd_r || pendPoll_r)) begin
        engStart_r      <= 1'b1;
        engReq_r.target <= target_r[7:1];
        engReq_r.wrData <= storeVal_r;
        engReq_r.count  <= burstLen;
        pollRead_r      <= !pendWr_r && !pendRd_r;
        if (pendWr_r) begin
          engReq_r.op      <= asm_pkg::ASM_OP_WRITE;
          engReq_r.regAddr <= storePtr_r;
        end else begin
          engReq_r.op      <= asm_pkg::ASM_OP_READ;
          engReq_r.regAddr <= fetch_r;
        end
      end
    end
  end

  asm_i2c_engine u_engine (
    .clk     (clk),
    .rst_n   (rst_n),
    .req     (engReq_r),
    .start   (engStart_r),
    .busy    (engBusy),
    .done    (engDone),
    .nack    (engNack),
    .rxValid (rxValid),
    .rxData  (rxData),
    .rxIdx   (rxIdx),
    .sclIn   (sclIn),
    .sclOut  (sclOut),
    .sclOe   (sclOe),
    .sdaIn   (sdaIn),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) auxBuf[i] <= 8'h00;
    end else if (rxValid) begin
      auxBuf[rxIdx] <= rxData;
    end
  end

  // acc samples pace frames; without acc, each good poll does if aux is enabled
  assign trigger = frame_r[`ASM_BIT_ACC] ? accStrobe :
                   (frame_r[`ASM_BIT_AUX] && engDone && pollRead_r &&
                    !engNack);
  assign hLen = frame_r[`ASM_BIT_HDR] ? 4'h1 : 4'h0;
  assign aLen = frame_r[`ASM_BIT_ACC] ? 4'(`ASM_AXIS_BYTES) : 4'h0;
  assign tags = {irqLineOne & frame_r[`ASM_BIT_TAG1],
                 irqLineTwo & frame_r[`ASM_BIT_TAG2]};

  // frames that arrive while one is still draining are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `ASM_FRAME_MAX; i++) frame[i] <= 8'h00;
      fLen_r <= '0;
      fIdx_r <= '0;
    end else if (trigger && fIdx_r == fLen_r) begin
      frame[0] <= {`ASM_HDR_TYPE, frame_r[`ASM_BIT_ACC],
                   frame_r[`ASM_BIT_AUX], tags, 2'h0};
      for (int k = 0; k < `ASM_AXIS_BYTES; k++) begin
        if (frame_r[`ASM_BIT_ACC]) frame[hLen + 4'(k)] <= accSample[8*k +: 8];
        if (frame_r[`ASM_BIT_AUX]) frame[hLen + aLen + 4'(k)] <= auxBuf[k];
      end
      if (!frame_r[`ASM_BIT_HDR] &&
          (frame_r[`ASM_BIT_TAG1] || frame_r[`ASM_BIT_TAG2]))
        frame[0][1:0] <= tags;
      fLen_r <= hLen + aLen +
                (frame_r[`ASM_BIT_AUX] ? 4'(`ASM_AXIS_BYTES) : 4'h0);
      fIdx_r <= '0;
    end else if (fIdx_r != fLen_r && bufReady) begin
      fIdx_r <= fIdx_r + 4'h1;
    end
  end

  assign bufIn.data = frame[fIdx_r];
  assign bufIn.last = (fIdx_r == fLen_r - 4'h1);

  asm_frame_buf u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (bufIn),
    .inValid  (fIdx_r != fLen_r),
    .inReady  (bufReady),
    .outData  (frameByte),
    .outValid (frameValid),
    .outReady (frameReady)
  );
endmodule

//--- rtl/asm_params.svh
// constants for the auxiliary sensor master block
`ifndef ASM_PARAMS_SVH
`define ASM_PARAMS_SVH
`define ASM_IDX_RATE      7'h44
`define ASM_IDX_FRAME     7'h49
`define ASM_IDX_STATUS    7'h4A
`define ASM_IDX_TARGET    7'h4B
`define ASM_IDX_SETUP     7'h4C
`define ASM_IDX_FETCH     7'h4D
`define ASM_IDX_STORE_PTR 7'h4E
`define ASM_IDX_STORE_VAL 7'h4F
`define ASM_RST_RATE      8'h46
`define ASM_RST_FRAME     8'h10
`define ASM_RST_TARGET    8'h20
`define ASM_RST_SETUP     8'h83
`define ASM_RST_FETCH     8'h42
`define ASM_RST_STORE_PTR 8'h4C
`define ASM_RST_STORE_VAL 8'h02
`define ASM_MSK_FRAME     8'h7C
`define ASM_MSK_TARGET    8'hFE
`define ASM_MSK_SETUP     8'h83
`define ASM_BIT_ACC       6
`define ASM_BIT_AUX       5
`define ASM_BIT_HDR       4
`define ASM_BIT_TAG1      3
`define ASM_BIT_TAG2      2
`define ASM_BIT_MANUAL    7
`define ASM_BL1           4'h1
`define ASM_BL2           4'h2
`define ASM_BL6           4'h6
`define ASM_BL8           4'h8
`define ASM_RATE_MIN      4'h1
`define ASM_RATE_MAX      4'hB
`define ASM_POLL_SLOW     11'h400
`define ASM_OFFSET_UNITS  2
`define ASM_HDR_TYPE      2'h2
`define ASM_AXIS_BYTES    6
`define ASM_FRAME_MAX     13
`define ASM_CLK_HZ        40000000
`define ASM_UNIT_US       1250
`define ASM_SCL_HZ        400000
`endif

//--- rtl/asm_pkg.sv
// shared types of the auxiliary sensor master block
package asm_pkg;
  typedef enum logic {ASM_OP_WRITE, ASM_OP_READ} asm_op_t;
  typedef struct packed {
    asm_op_t    op;
    logic [6:0] target;
    logic [7:0] regAddr;
    logic [7:0] wrData;
    logic [3:0] count;
  } asm_i2c_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } asm_fbyte_t;
  typedef enum {
    ASM_ST_IDLE, ASM_ST_S1, ASM_ST_AW, ASM_ST_RG, ASM_ST_WD,
    ASM_ST_S2, ASM_ST_AR, ASM_ST_RD, ASM_ST_P
  } asm_step_t;
endpackage

//--- rtl/asm_frame_buf.sv
// two-entry frame byte buffer with valid/ready on both sides
module asm_frame_buf (
  input  wire logic              clk,      // system clock
  input  wire logic              rst_n,    // async reset, active low
  input  wire asm_pkg::asm_fbyte_t inData, // byte from frame builder
  input  wire logic              inValid,  // inData valid
  output logic                   inReady,  // room for a byte
  output asm_pkg::asm_fbyte_t    outData,  // byte to consumer
  output logic                   outValid, // outData valid
  input  wire logic              outReady  // consumer takes byte
);
  asm_pkg::asm_fbyte_t tail_r;
  logic                tailV_r;
  logic                push;
  logic                pop;

  // full only when the second slot holds a word
  assign inReady = !tailV_r;
  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outData  <= '0;
      outValid <= 1'b0;
      tail_r   <= '0;
      tailV_r  <= 1'b0;
    end else if (!outValid || pop) begin
      if (tailV_r) begin
        outData  <= tail_r;
        outValid <= 1'b1;
        tail_r   <= inData;
        tailV_r  <= push;
      end else begin
        outData  <= inData;
        outValid <= push;
      end
    end else if (push) begin
      tail_r  <= inData;
      tailV_r <= 1'b1;
    end
  end
endmodule

//--- rtl/asm_i2c_engine.sv
// open-drain i2c master sequencer for one write or one burst read
`include "asm_params.svh"
module asm_i2c_engine (
  input  wire logic                  clk,     // system clock
  input  wire logic                  rst_n,   // async reset, active low
  input  wire asm_pkg::asm_i2c_req_t req,     // transfer description
  input  wire logic                  start,   // pulse, take req
  output logic                       busy,    // transfer in progress
  output logic                       done,    // pulse at end
  output logic                       nack,    // last transfer nacked
  output logic                       rxValid, // pulse, rxData valid
  output logic [7:0]                 rxData,  // received byte
  output logic [2:0]                 rxIdx,   // position in burst
  input  wire logic                  sclIn,   // scl pin level
  output logic                       sclOut,  // scl drive value
  output logic                       sclOe,   // scl pulled low
  input  wire logic                  sdaIn,   // sda pin level
  output logic                       sdaOut,  // sda drive value
  output logic                       sdaOe    // sda pulled low
);
  localparam int unsigned QTR = `ASM_CLK_HZ / (4 * `ASM_SCL_HZ);
  asm_pkg::asm_step_t    step_r;
  asm_pkg::asm_i2c_req_t req_r;
  logic [5:0] qCnt_r;
  logic       tick;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [3:0] left_r;
  logic [7:0] shift_r;
  logic       ackHi_r;
  logic       sclS1_r, sclS2_r, sdaS1_r, sdaS2_r;
  logic [7:0] txByte;
  logic       isTx;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclS1_r <= 1'b1;
      sclS2_r <= 1'b1;
      sdaS1_r <= 1'b1;
      sdaS2_r <= 1'b1;
    end else begin
      sclS1_r <= sclIn;
      sclS2_r <= sclS1_r;
      sdaS1_r <= sdaIn;
      sdaS2_r <= sdaS1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) qCnt_r <= '0;
    else if (tick || step_r == asm_pkg::ASM_ST_IDLE) qCnt_r <= '0;
    else qCnt_r <= qCnt_r + 6'h1;
  end
  assign tick = (qCnt_r == 6'(QTR - 1));

  always_comb begin
    isTx = 1'b1;
    case (step_r)
      asm_pkg::ASM_ST_AW: txByte = {req_r.target, 1'b0};
      asm_pkg::ASM_ST_AR: txByte = {req_r.target, 1'b1};
      asm_pkg::ASM_ST_RG: txByte = req_r.regAddr;
      asm_pkg::ASM_ST_WD: txByte = req_r.wrData;
      default: begin
        txByte = 8'h00;
        isTx   = 1'b0;
      end
    endcase
  end

  assign busy   = (step_r != asm_pkg::ASM_ST_IDLE);
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_r  <= asm_pkg::ASM_ST_IDLE;
      req_r   <= '0;
      ph_r    <= 2'h0;
      bit_r   <= 4'h0;
      left_r  <= 4'h0;
      shift_r <= 8'h00;
      ackHi_r <= 1'b0;
      sclOe   <= 1'b0;
      sdaOe   <= 1'b0;
      done    <= 1'b0;
      nack    <= 1'b0;
      rxValid <= 1'b0;
      rxData  <= 8'h00;
      rxIdx   <= 3'h0;
    end else begin
      done    <= 1'b0;
      rxValid <= 1'b0;
      if (step_r == asm_pkg::ASM_ST_IDLE) begin
        if (start) begin
          req_r  <= req;
          left_r <= req.count;
          rxIdx  <= 3'h0;
          nack   <= 1'b0;
          ph_r   <= 2'h0;
          step_r <= asm_pkg::ASM_ST_S1;
        end
      // a target holding scl low stretches the high phase
      end else if (tick && !(ph_r == 2'h2 && !sclS2_r)) begin
        ph_r <= ph_r + 2'h1;
        case (ph_r)
          2'h0: begin
            if (isTx) sdaOe <= (bit_r < 4'h8) && !txByte[3'h7 - bit_r[2:0]];
            else if (step_r == asm_pkg::ASM_ST_RD)
              sdaOe <= (bit_r == 4'h8) && (left_r != 4'h1);
            else sdaOe <= (step_r == asm_pkg::ASM_ST_P);
          end
          2'h1: sclOe <= 1'b0;
          2'h2: begin
            if (step_r == asm_pkg::ASM_ST_S1 || step_r == asm_pkg::ASM_ST_S2)
              sdaOe <= 1'b1;
            else if (step_r == asm_pkg::ASM_ST_P) sdaOe <= 1'b0;
            else if (bit_r == 4'h8) ackHi_r <= sdaS2_r;
            else shift_r <= {shift_r[6:0], sdaS2_r};
          end
          default: begin
            sclOe <= (step_r != asm_pkg::ASM_ST_P);
            bit_r <= 4'h0;
            case (step_r)
              asm_pkg::ASM_ST_S1: step_r <= asm_pkg::ASM_ST_AW;
              asm_pkg::ASM_ST_S2: step_r <= asm_pkg::ASM_ST_AR;
              asm_pkg::ASM_ST_P: begin
                step_r <= asm_pkg::ASM_ST_IDLE;
                done   <= 1'b1;
              end
              asm_pkg::ASM_ST_RD: begin
                if (bit_r != 4'h8) bit_r <= bit_r + 4'h1;
                else begin
                  rxValid <= 1'b1;
                  rxData  <= shift_r;
                  rxIdx   <= 3'(req_r.count - left_r);
                  left_r  <= left_r - 4'h1;
                  if (left_r == 4'h1) step_r <= asm_pkg::ASM_ST_P;
                end
              end
              default: begin
                if (bit_r != 4'h8) bit_r <= bit_r + 4'h1;
                else if (ackHi_r) begin
                  nack   <= 1'b1;
                  step_r <= asm_pkg::ASM_ST_P;
                end else if (step_r == asm_pkg::ASM_ST_AW)
                  step_r <= asm_pkg::ASM_ST_RG;
                else if (step_r == asm_pkg::ASM_ST_AR)
                  step_r <= asm_pkg::ASM_ST_RD;
                else if (step_r == asm_pkg::ASM_ST_RG &&
                         req_r.op == asm_pkg::ASM_OP_READ)
                  step_r <= asm_pkg::ASM_ST_S2;
                else if (step_r == asm_pkg::ASM_ST_RG)
                  step_r <= asm_pkg::ASM_ST_WD;
                else step_r <= asm_pkg::ASM_ST_P;
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule

//--- tb/asm_aux_master_properties.sv
// port checker for the auxiliary sensor master
module asm_aux_master_checker (
  input wire logic                clk,        // clock
  input wire logic                rst_n,      // reset, low
  input wire logic                wb_cyc_i,   // bus cycle
  input wire logic                wb_stb_i,   // bus strobe
  input wire logic                wb_we_i,    // bus write
  input wire logic [8:0]          wb_adr_i,   // byte address
  input wire logic [31:0]         wb_dat_o,   // read data
  input wire logic                wb_ack_o,   // acknowledge
  input wire asm_pkg::asm_fbyte_t frameByte,  // stream byte
  input wire logic                frameValid, // byte valid
  input wire logic                frameReady, // consumer ready
  input wire logic                sclOut,     // clock drive
  input wire logic                sdaOut      // data drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rdAck;
  logic [6:0] ix;
  assign rdAck = wb_ack_o && !wb_we_i;
  assign ix = wb_adr_i[8:2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_one_cycle: assert property (s_req |=> s_ack)
    else $error("ack late or long");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_frame_resv_zero: assert property (rdAck && ix == 7'h49 |->
    (wb_dat_o[7:0] & 8'h83) == 8'h00) else $error("frame reserved bits");
  a_target_bit_zero: assert property (rdAck && ix == 7'h4B |->
    !wb_dat_o[0]) else $error("target bit zero set");
  a_setup_resv_zero: assert property (rdAck && ix == 7'h4C |->
    wb_dat_o[6:2] == 5'h00) else $error("setup reserved bits");
  a_frame_byte_hold: assert property (frameValid && !frameReady |=>
    frameValid && $stable(frameByte)) else $error("byte not held");
  a_open_drain_low: assert property (!sclOut && !sdaOut)
    else $error("pin driven high");
endmodule
bind asm_aux_master asm_aux_master_checker u_chk (.clk, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .frameByte,
  .frameValid, .frameReady, .sclOut, .sdaOut);

//--- tb/asm_i2c_target_model.sv
// behavioural sensor on the auxiliary i2c bus
module asm_i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h10
) (
  input  wire logic scl,     // clock level
  input  wire logic sda,     // data level
  input  wire logic slow,    // stretch clock
  output logic      sdaPull, // pull data low
  output logic      sclPull  // pull clock low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh, v;
  logic       rd, on;
  int         bitc, byteNo, sent;
  logic [7:0] got[$];
  initial {sdaPull, sclPull, on} = 3'b000;
  // start or repeated start
  always @(negedge sda) if (scl) begin
    {on, rd, sdaPull} = 3'b100;
    bitc = -1;
    byteNo = -1;
    sent = 0;
  end
  always @(posedge sda) if (scl) on = 1'b0;
  always @(posedge scl) if (on) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else if (rd && byteNo > 0 && sda) on = 1'b0;
  end
  always @(negedge scl) if (on) begin
    bitc = (bitc == 8) ? 0 : bitc + 1;
    sdaPull = 1'b0;
    if (bitc == 8 && !(rd && byteNo > 0)) begin
      got.push_back(sh);
      if (byteNo == 0) rd = sh[0];
      // a foreign address is left unanswered
      sdaPull = byteNo > 0 || sh[7:1] == ADDR;
      on = sdaPull;
    end else if (bitc == 0) begin
      byteNo++;
      sent += int'(rd);
      // slow answer holds the clock low after each byte
      if (slow) begin sclPull = 1'b1; #2000 sclPull = 1'b0; end
    end
    v = 8'hA0 + 8'(sent - 1);
    if (rd && byteNo > 0 && bitc < 8) sdaPull = !v[7 - bitc];
  end
endmodule

//--- tb/tb_asm_aux_master.sv
// self-checking bench for the auxiliary sensor master
module tb_asm_aux_master;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, rst_n, cyc, stb, we, acs, i1, i2, rdy, slow;
  logic [3:0]          sel;
  logic [8:0]          adr;
  logic [31:0]         dat, rdat;
  logic [47:0]         acc;
  logic [7:0]          q;
  logic                ack, fv, sclOe, sdaOe, tSda, tScl;
  asm_pkg::asm_fbyte_t fb;
  int                  error_cnt, tests_run;
  wire                 sclW = !(sclOe | tScl);
  wire                 sdaW = !(sdaOe | tSda);
  asm_aux_master #(.UNIT_CYC(20)) dut (
    .clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .accSample(acc), .accStrobe(acs), .irqLineOne(i1),
    .irqLineTwo(i2), .frameByte(fb), .frameValid(fv), .frameReady(rdy),
    .sclIn(sclW), .sclOut(), .sclOe, .sdaIn(sdaW), .sdaOut(), .sdaOe);
  asm_i2c_target_model tgt (
    .scl(sclW), .sda(sdaW), .slow, .sdaPull(tSda), .sclPull(tScl));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("mismatches %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [6:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
    {adr, dat} <= {ix, 2'b00, 24'h0, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t bus timeout", $time);
    end
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask
  // poll status until the engine is idle
  task automatic idle();
    int n;
    n = 0;
    do begin wb(0, 7'h4A, 8'h00); n++; end while (q[0] !== 1'b0 && n < 9000);
    if (q[0] !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH %0t link timeout", $time);
    end
  endtask
  task automatic gotchk(input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] c);
    chk(8'(tgt.got.size()), 8'h03);
    chk(tgt.got[0], a);
    chk(tgt.got[1], b);
    chk(tgt.got[2], c);
    tgt.got.delete();
  endtask
  task automatic regs();
    logic [6:0] ix[12] = '{7'h44, 7'h49, 7'h4B, 7'h4C, 7'h4D, 7'h4E, 7'h4F,
                           7'h50, 7'h49, 7'h4B, 7'h4C, 7'h50};
    logic [7:0] ev[12] = '{8'h46, 8'h10, 8'h20, 8'h83, 8'h42, 8'h4C, 8'h02,
                           8'h00, 8'h7C, 8'hFE, 8'h83, 8'h00};
    for (int k = 0; k < 12; k++) begin
      if (k > 7) wb(1, ix[k], 8'hFF);
      wb(0, ix[k], 8'h00);
      chk(q, ev[k]);
    end
  endtask
  task automatic writes();
    tgt.got.delete();
    wb(1, 7'h4F, 8'h3C);
    idle();
    chk(q & 8'h02, 8'h02);
    chk(tgt.got[0], 8'hFE);
    wb(1, 7'h4B, 8'h20);
    slow = 1'b1;
    tgt.got.delete();
    wb(1, 7'h4E, 8'h5A);
    wb(1, 7'h4F, 8'hC3);
    idle();
    gotchk(8'h20, 8'h5A, 8'hC3);
  endtask
  task automatic reads();
    logic [7:0] nb[4] = '{8'h01, 8'h02, 8'h06, 8'h08};
    for (int k = 0; k < 4; k++) begin
      wb(1, 7'h4C, 8'h80 | 8'(k));
      wb(1, 7'h4D, 8'h30 + 8'(k));
      idle();
      gotchk(8'h20, 8'h30 + 8'(k), 8'h21);
      chk(8'(tgt.sent), nb[k]);
    end
  endtask
  task automatic frame(input logic [7:0] cfg, input logic trig);
    logic [7:0] e[$];
    logic       t1, t2;
    int         n, k;
    wb(1, 7'h49, cfg);
    t1 = cfg[3] & i1;
    t2 = cfg[2] & i2;
    if (cfg[4]) e.push_back({2'b10, cfg[6], cfg[5], t1, t2, 2'b00});
    if (cfg[6]) for (k = 0; k < 6; k++) e.push_back(acc[8*k +: 8]);
    if (cfg[5]) for (k = 0; k < 6; k++) e.push_back(8'hA0 + 8'(k));
    if (!cfg[4] && (cfg[3] | cfg[2])) e[0][1:0] = {t1, t2};
    if (trig) begin
      @(posedge clk) acs <= 1'b1;
      @(posedge clk) acs <= 1'b0;
    end
    // consumer stalls every other cycle
    {k, n} = '0;
    while (k < e.size() && n < 30000) begin
      @(posedge clk);
      n++;
      if (fv === 1'b1 && rdy === 1'b1) begin
        chk(fb.data, e[k]);
        chk(8'(fb.last), 8'(k == e.size() - 1));
        k++;
      end
      rdy <= n[0];
    end
    chk(8'(k), 8'(e.size()));
  endtask
  initial begin
    {rst_n, cyc, stb, we, acs, rdy, slow, i2, sel, adr, dat} = '0;
    i1 = 1'b1;
    acc = 48'h6655_4433_2212;
    {error_cnt, tests_run} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    regs();
    writes();
    reads();
    frame(8'h7C, 1'b1);
    frame(8'h40, 1'b1);
    frame(8'h58, 1'b1);
    frame(8'h44, 1'b1);
    wb(1, 7'h44, 8'h0B);
    wb(1, 7'h4C, 8'h03);
    frame(8'h20, 1'b0);
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
